// ---- gated_16bit_counter.sv ----
`default_nettype none
// What this block does
// - count clock chosen: instruction clock, system clock, external pin edges, low-frequency oscillator
// - prescaler divides the chosen count clock by one, two, four or eight
// - sync_bypass clear adds a synchronising stage to the external count input
// - timer_on runs the counter; clearing it stops counting and clears toggle flop
// - gate_enable ignored when off; when set the gate decides counting
// - gate_polarity picks whether a high or a low gate allows counting
// - toggle mode passes gate through a flop toggling on rising edges
// - gate_single_pulse_mode puts the gate under single-pulse control
// - single_pulse_go reads one while armed, hardware clears it when done
// - gate_level_status shows the gate state regardless of gate_enable
// - gate source chosen from pin, timer0 wrap, comparator a or b
// - control bits 3 and 1 read zero and ignore writes
// - writable fields reset to zero on power-on reset
// - count visible as high byte and low byte registers
// - count wraps from all ones to zero and sets rollover_flag
// - falling edge of gate_level_status sets gate_event_flag
// - single-pulse go clears on trailing edge; no counting until rearmed
// - timer0 wrapping from maximum to zero makes a wrap pulse for the gate
module gated_16bit_counter
    import gated_counter_pkg::*;
#(
    parameter int SYNC_STAGES = 3
)(
    input wire logic clk, // system clock
    input wire logic reset_n, // power-on or brown-out reset
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic external_count_input, // asynchronous count pin
    input wire logic low_freq_internal_osc, // asynchronous slow oscillator
    input wire logic gate_pin, // asynchronous gate pin
    input wire logic comparator_a_out, // asynchronous comparator output
    input wire logic comparator_b_out, // asynchronous comparator output
    input wire logic [7:0] timer0_value, // sibling timer count, same clock
    output logic irq // level interrupt
);

    // the synchroniser below is built for exactly three stages
    if (SYNC_STAGES != 3)
    begin : g_bad_stages
        $error("SYNC_STAGES must be 3");
    end

    // ************************************************************
    // pin synchronisers: three flops, stage one read only by stage two
    // ************************************************************
    logic [4:0] pin_s1, pin_s2, pin_s3, pin_level;
    logic [4:0] pin_raw;
    assign pin_raw = {comparator_b_out, comparator_a_out, gate_pin, low_freq_internal_osc, external_count_input};

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
            pin_level <= '0;
        end
        else
        begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            for (int i = 0; i < 5; i++)
                if (pin_s2[i] == pin_s3[i])
                    pin_level[i] <= pin_s3[i];
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    timer_control_t tcon;
    gate_control_t gcon;
    logic [15:0] count;
    logic [1:0] irq_status, irq_enable;

    logic wr_access, rd_setup;
    assign wr_access = psel && penable && pready && pwrite;
    assign rd_setup = psel && !penable;

    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a == ADDR_TIMER_CONTROL) || (a == ADDR_GATE_CONTROL) || (a == ADDR_COUNT_HIGH)
            || (a == ADDR_COUNT_LOW) || (a == ADDR_IRQ_STATUS) || (a == ADDR_IRQ_CLEAR) || (a == ADDR_IRQ_ENABLE);
    endfunction : addr_mapped

    logic wr_tcon, wr_gcon, wr_high, wr_low, wr_clear, wr_enable;
    assign wr_tcon = wr_access && (paddr == ADDR_TIMER_CONTROL);
    assign wr_gcon = wr_access && (paddr == ADDR_GATE_CONTROL);
    assign wr_high = wr_access && (paddr == ADDR_COUNT_HIGH);
    assign wr_low = wr_access && (paddr == ADDR_COUNT_LOW);
    assign wr_clear = wr_access && (paddr == ADDR_IRQ_CLEAR);
    assign wr_enable = wr_access && (paddr == ADDR_IRQ_ENABLE);

    // ************************************************************
    // clock source and prescaler
    // ************************************************************
    logic [1:0] instr_div;
    logic ext_level_d, ext_sync_level, lf_level_d;
    logic ext_used, src_tick, pre_tick;
    logic [2:0] pre_count, pre_last;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            instr_div <= '0;
        else
            instr_div <= instr_div + 2'h1;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ext_sync_level <= 1'b0;
            ext_level_d <= 1'b0;
            lf_level_d <= 1'b0;
        end
        else
        begin
            ext_sync_level <= pin_level[0];
            ext_level_d <= ext_used;
            lf_level_d <= pin_level[1];
        end
    end
    assign ext_used = tcon.sync_bypass ? pin_level[0] : ext_sync_level;

    always_comb
    begin
        case (tcon.clock_source_select)
            SRC_LF_OSC: src_tick = pin_level[1] && !lf_level_d;
            SRC_EXT_PIN: src_tick = ext_used && !ext_level_d;
            SRC_SYS_CLK: src_tick = 1'b1;
            default: src_tick = (instr_div == INSTR_DIV_LAST);
        endcase
    end

    // divide by 1, 2, 4 or 8
    assign pre_last = 3'((4'h1 << tcon.input_prescale_select) - 4'h1);
    assign pre_tick = src_tick && (pre_count == pre_last);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            pre_count <= '0;
        else if (!tcon.timer_on || pre_tick)
            pre_count <= '0;
        else if (src_tick)
            pre_count <= pre_count + 3'h1;
    end

    // ************************************************************
    // gate source, toggle, polarity, single pulse
    // ************************************************************
    logic timer0_prev, timer0_wrap_pulse;
    logic gate_src, gate_src_d, toggle_ff, gate_mode_level, gate_active;
    logic sp_active_d, gate_view, gate_view_d, gate_allows, count_en;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            timer0_prev <= 1'b0;
            timer0_wrap_pulse <= 1'b0;
        end
        else
        begin
            timer0_prev <= (timer0_value == TIMER0_MAX);
            timer0_wrap_pulse <= timer0_prev && (timer0_value == TIMER0_ZERO);
        end
    end

    always_comb
    begin
        case (gcon.gate_source_select)
            GATE_FROM_TIMER0: gate_src = timer0_wrap_pulse;
            GATE_FROM_CMP_A: gate_src = pin_level[3];
            GATE_FROM_CMP_B: gate_src = pin_level[4];
            default: gate_src = pin_level[2];
        endcase
    end

    // toggle flop, held clear outside toggle mode
    // also cleared while the timer is off
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gate_src_d <= 1'b0;
            toggle_ff <= 1'b0;
        end
        else
        begin
            gate_src_d <= gate_src;
            if (!gcon.gate_toggle_mode || !tcon.timer_on)
                toggle_ff <= 1'b0;
            else if (gate_src && !gate_src_d)
                toggle_ff <= !toggle_ff;
        end
    end

    assign gate_mode_level = gcon.gate_toggle_mode ? toggle_ff : gate_src;
    assign gate_active = gcon.gate_polarity ? gate_mode_level : !gate_mode_level;
    // single pulse gates the active level through go
    assign gate_view = gcon.gate_single_pulse_mode ? (gate_active && gcon.single_pulse_go) : gate_active;
    // gate only matters with gate_enable set
    assign gate_allows = !gcon.gate_enable || gate_view;
    assign count_en = tcon.timer_on && gate_allows && pre_tick;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sp_active_d <= 1'b0;
            gate_view_d <= 1'b0;
        end
        else
        begin
            sp_active_d <= gate_active && gcon.single_pulse_go;
            gate_view_d <= gate_view;
        end
    end

    logic sp_done;
    // trailing edge of the captured pulse ends the acquisition
    assign sp_done = gcon.gate_single_pulse_mode && sp_active_d && !gate_active;

    // ************************************************************
    // control registers
    // ************************************************************
    // zero on power-on reset
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            tcon <= TIMER_CONTROL_RESET;
        else if (wr_tcon)
        begin
            tcon <= pwdata[7:0];
            tcon.unused_3 <= 1'b0;
            tcon.unused_1 <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            gcon <= GATE_CONTROL_RESET;
        else
        begin
            if (wr_gcon)
            begin
                gcon.gate_enable <= pwdata[7];
                gcon.gate_polarity <= pwdata[6];
                gcon.gate_toggle_mode <= pwdata[5];
                gcon.gate_single_pulse_mode <= pwdata[4];
                gcon.gate_source_select <= gate_source_t'(pwdata[1:0]);
            end
            // software arms; hardware clears; a write of one with bit 4 set wins
            if (wr_gcon && pwdata[GO_BIT] && pwdata[4])
                gcon.single_pulse_go <= 1'b1;
            else if ((wr_gcon && !pwdata[GO_BIT]) || sp_done || !gcon.gate_single_pulse_mode)
                gcon.single_pulse_go <= 1'b0;
            // live gate level, independent of gate_enable
            gcon.gate_level_status <= gate_view;
        end
    end

    // ************************************************************
    // counter
    // ************************************************************
    logic [15:0] next_count;
    logic wrap;
    assign wrap = count_en && (count == 16'hffff);
    assign next_count = count_en ? count + 16'h1 : count;

    // byte writes replace the matching byte
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            count <= COUNT_RESET;
        else
            count <= {wr_high ? pwdata[7:0] : next_count[15:8], wr_low ? pwdata[7:0] : next_count[7:0]};
    end

    // ************************************************************
    // interrupts: sticky status, set wins over clear
    // ************************************************************
    logic [1:0] irq_set;
    logic gate_fall;
    // falling edge of the visible gate level
    assign gate_fall = gate_view_d && !gate_view;
    assign irq_set = {gate_fall, wrap};

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_status <= IRQ_RESET;
            irq_enable <= IRQ_RESET;
            irq <= 1'b0;
        end
        else
        begin
            irq_status <= irq_set | (irq_status & ~(wr_clear ? pwdata[1:0] : 2'h0));
            if (wr_enable)
                irq_enable <= pwdata[1:0];
            irq <= |(irq_status & irq_enable);
        end
    end

    // ************************************************************
    // apb slave: one access cycle, read data taken at setup
    // ************************************************************
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= rd_setup;
            pslverr <= rd_setup && !addr_mapped(paddr);
            if (rd_setup && !pwrite)
            begin
                if (paddr == ADDR_TIMER_CONTROL)
                    prdata <= {24'h0, tcon};
                else if (paddr == ADDR_GATE_CONTROL)
                    prdata <= {24'h0, gcon};
                else if (paddr == ADDR_COUNT_HIGH)
                    prdata <= {24'h0, count[15:8]};
                else if (paddr == ADDR_COUNT_LOW)
                    prdata <= {24'h0, count[7:0]};
                else if (paddr == ADDR_IRQ_STATUS)
                    prdata <= {30'h0, irq_status};
                else if (paddr == ADDR_IRQ_ENABLE)
                    prdata <= {30'h0, irq_enable};
                else
                    prdata <= '0;
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    chk_off_no_count: assert property (!tcon.timer_on |=> $stable(count) || $past(wr_high || wr_low))
        else $error("count moved while timer off");
    chk_toggle_clear: assert property (!gcon.gate_toggle_mode |=> !toggle_ff)
        else $error("toggle flop not held clear");
    chk_unused_zero: assert property (!tcon.unused_3 && !tcon.unused_1)
        else $error("unused control bits set");
    chk_wrap_flag: assert property (wrap |=> irq_status[IRQ_ROLLOVER_BIT] && count == 16'h0000)
        else $error("wrap did not set rollover");
    chk_gate_event: assert property (gate_fall |=> irq_status[IRQ_GATE_EVENT_BIT])
        else $error("gate fall did not set flag");
    chk_go_done: assert property (sp_done && !wr_gcon |=> !gcon.single_pulse_go)
        else $error("go not cleared at pulse end");
    chk_gate_view: assert property ($past(reset_n) |-> gcon.gate_level_status == $past(gate_view))
        else $error("gate status mismatch");
    chk_gate_block: assert property (tcon.timer_on && gcon.gate_enable && !gate_view && !wr_high && !wr_low
        |=> $stable(count))
        else $error("count moved with gate closed");
    chk_sys_clk_rate: assert property (tcon.timer_on && !gcon.gate_enable && tcon.clock_source_select == SRC_SYS_CLK
        && tcon.input_prescale_select == 2'b00 && !wr_access [*2] |-> count == $past(count) + 16'h1)
        else $error("system clock source not counting every cycle");
    chk_apb_ready: assert property (rd_setup |=> pready ##1 !pready) // apb
        else $error("pready not one cycle");

    cov_wrap: cover property (wrap);
    cov_gate_event: cover property (gate_fall && gcon.gate_enable);
    cov_single_pulse: cover property (gcon.single_pulse_go ##[1:200] sp_done);
    cov_toggle: cover property (gcon.gate_toggle_mode && $rose(toggle_ff));

endmodule : gated_16bit_counter
`default_nettype wire

// ---- gated_counter_pkg.sv ----
`default_nettype none
package gated_counter_pkg;

    // ************************************************************
    // register map, byte addresses of 32-bit aligned words
    // ************************************************************
    localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_GATE_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h08;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h14;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int GO_BIT = 3;
    localparam int IRQ_ROLLOVER_BIT = 0;
    localparam int IRQ_GATE_EVENT_BIT = 1;
    localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
    localparam logic [7:0] GATE_CONTROL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    localparam logic [7:0] TIMER0_MAX = 8'hff;
    localparam logic [7:0] TIMER0_ZERO = 8'h00;
    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;

    // ************************************************************
    // encodings
    // ************************************************************
    typedef enum logic [1:0] {
        SRC_INSTR_CLK = 2'b00,
        SRC_SYS_CLK = 2'b01,
        SRC_EXT_PIN = 2'b10,
        SRC_LF_OSC = 2'b11
    } clock_source_t;

    typedef enum logic [1:0] {
        GATE_FROM_PIN = 2'b00,
        GATE_FROM_TIMER0 = 2'b01,
        GATE_FROM_CMP_A = 2'b10,
        GATE_FROM_CMP_B = 2'b11
    } gate_source_t;

    typedef struct packed {
        clock_source_t clock_source_select;
        logic [1:0] input_prescale_select;
        logic unused_3;
        logic sync_bypass;
        logic unused_1;
        logic timer_on;
    } timer_control_t;

    typedef struct packed {
        logic gate_enable;
        logic gate_polarity;
        logic gate_toggle_mode;
        logic gate_single_pulse_mode;
        logic single_pulse_go;
        logic gate_level_status;
        gate_source_t gate_source_select;
    } gate_control_t;

endpackage : gated_counter_pkg
`default_nettype wire

// ---- tb_gated_16bit_counter.sv ----
`default_nettype none
`define CHECK(got, exp) \
begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
        fail_count++; \
        $display("Error %0t: got %h expected %h", $time, got, exp); \
    end \
end
module tb_gated_16bit_counter
    import gated_counter_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [31:0] d;
        logic [31:0] m;
        logic [31:0] t;
        logic e;
    } note_t;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic external_count_input = 1'b0;
    logic low_freq_internal_osc = 1'b0;
    logic gate_pin = 1'b0;
    logic comparator_a_out = 1'b0;
    logic comparator_b_out = 1'b0;
    logic [7:0] timer0_value = 8'h00;
    logic irq;
    logic [3:0] div = 4'h0;
    int fail_count = 0;
    int n_tests = 0;
    int seed = 32'haaf5;
    note_t notes[$];
    note_t cur;
    logic [31:0] got;
    logic [31:0] dif;

    gated_16bit_counter #(.SYNC_STAGES(3)) gated_16bit_counter_inst (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_count_input(external_count_input), .low_freq_internal_osc(low_freq_internal_osc),
        .gate_pin(gate_pin), .comparator_a_out(comparator_a_out), .comparator_b_out(comparator_b_out),
        .timer0_value(timer0_value), .irq(irq)
    );

    always #5 clk = ~clk;

    // slow pins toggle every 8 cycles; the sibling timer free-runs and wraps every 256
    always @(posedge clk)
    begin
        div <= div + 4'h1;
        external_count_input <= div[3];
        low_freq_internal_osc <= div[3];
        timer0_value <= timer0_value + 8'h01;
    end

    // ************************************************************
    // scoreboard: every transfer leaves a note, checked at pready
    // ************************************************************
    always @(posedge clk)
    begin
        if (psel && penable && pready === 1'b1)
        begin
            if (notes.size() == 0) `CHECK(1'b1, 1'b0)
            else
            begin
                cur = notes.pop_front();
                got = prdata & cur.m;
                dif = (got > cur.d) ? got - cur.d : cur.d - got;
                `CHECK(pslverr, cur.e)
                `CHECK(dif <= cur.t, 1'b1)
            end
        end
    end

    task finish_test();
        $display("tests %0d errors %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, input note_t n);
        int i;
        notes.push_back(n);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        if (i == 20)
        begin
            fail_count++;
            finish_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : xfer

    task wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, {24'h0, d}, '{32'h0, 32'h0, 32'h0, 1'b0});
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m, input int t);
        xfer(1'b0, a, 32'h0, '{{24'h0, e}, {24'h0, m}, t, 1'b0});
    endtask : rd

    task rdc(input logic [15:0] e, input int t);
        rd(ADDR_COUNT_HIGH, e[15:8], 8'hff, 0);
        rd(ADDR_COUNT_LOW, e[7:0], 8'hff, t);
    endtask : rdc

    // counts from zero; a start plus cyc(61) plus a stop spans about 64 system clocks
    task start(input logic [7:0] ctrl, input logic [7:0] gate);
        wr(ADDR_COUNT_HIGH, 8'h00);
        wr(ADDR_COUNT_LOW, 8'h00);
        wr(ADDR_GATE_CONTROL, gate);
        wr(ADDR_TIMER_CONTROL, ctrl);
    endtask : start

    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        int ex[5];
        int i;
        int k;
        logic [31:0] r;
        logic [1:0] s;
        ex = '{16, 64, 4, 4, 4};
        cyc(2);
        reset_n <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 7; i++)
            rd(8'(4 * i), 8'h00, 8'hfb, 0);
        xfer(1'b0, 8'h1c, 32'h0, '{32'h0, 32'hffffffff, 32'h0, 1'b1});
        wr(ADDR_TIMER_CONTROL, 8'hfa);
        rd(ADDR_TIMER_CONTROL, 8'hf0, 8'hff, 0);
        wr(ADDR_TIMER_CONTROL, 8'h00);
        for (i = 0; i < 4; i++)
        begin
            r = $random(seed);
            wr(ADDR_COUNT_HIGH, r[7:0]);
            wr(ADDR_COUNT_LOW, r[15:8]);
            rdc({r[7:0], r[15:8]}, 0);
        end
        // the last pass runs the pin source again with the extra sync stage bypassed
        for (i = 0; i < 5; i++)
        begin
            s = (i == 4) ? 2'b10 : 2'(i);
            start({s, 2'b00, 1'b0, i >= 3, 1'b0, 1'b1}, 8'h00);
            cyc(61);
            wr(ADDR_TIMER_CONTROL, 8'h00);
            rdc(16'(ex[i]), 1);
        end
        for (i = 0; i < 4; i++)
        begin
            start({2'b01, 2'(i), 4'b0001}, 8'h00);
            cyc(61);
            wr(ADDR_TIMER_CONTROL, 8'h00);
            rdc(16'(64 >> i), 2);
        end
        // the pin and both comparator gate sources are each driven to their level while the others sit opposite
        for (k = 0; k < 12; k++)
        begin
            s = (k / 4 == 0) ? 2'b00 : 2'(k / 4 + 1);
            gate_pin <= (s == 2'b00) ? k[0] : ~k[0];
            comparator_a_out <= (s == 2'b10) ? k[0] : ~k[0];
            comparator_b_out <= (s == 2'b11) ? k[0] : ~k[0];
            cyc(8);
            start(8'h41, {1'b1, k[1], 4'b0000, s});
            cyc(61);
            wr(ADDR_TIMER_CONTROL, 8'h00);
            rdc((k[0] == k[1]) ? 16'd64 : 16'd0, (k[0] == k[1]) ? 2 : 0);
        end
        gate_pin <= 1'b0;
        comparator_a_out <= 1'b0;
        comparator_b_out <= 1'b0;
        // toggle: a short pulse opens the gate until the next rising edge
        start(8'h41, 8'he0);
        gate_pin <= 1'b1;
        cyc(4);
        gate_pin <= 1'b0;
        cyc(57);
        wr(ADDR_TIMER_CONTROL, 8'h00);
        rdc(16'd62, 6);
        start(8'h41, 8'he0);
        cyc(61);
        wr(ADDR_TIMER_CONTROL, 8'h00);
        rdc(16'd0, 0);
        // single pulse: only the first pulse after arming is counted
        start(8'h41, 8'hd8);
        rd(ADDR_GATE_CONTROL, 8'h08, 8'h08, 0);
        gate_pin <= 1'b1;
        cyc(8);
        gate_pin <= 1'b0;
        cyc(16);
        gate_pin <= 1'b1;
        cyc(8);
        gate_pin <= 1'b0;
        cyc(8);
        wr(ADDR_TIMER_CONTROL, 8'h00);
        rdc(16'd8, 2);
        rd(ADDR_GATE_CONTROL, 8'h00, 8'h08, 0);
        wr(ADDR_IRQ_CLEAR, 8'h03);
        wr(ADDR_GATE_CONTROL, 8'h40);
        wr(ADDR_TIMER_CONTROL, 8'h41);
        gate_pin <= 1'b1;
        cyc(8);
        rd(ADDR_GATE_CONTROL, 8'h04, 8'h04, 0);
        gate_pin <= 1'b0;
        cyc(8);
        rd(ADDR_GATE_CONTROL, 8'h00, 8'h04, 0);
        rd(ADDR_IRQ_STATUS, 8'h02, 8'h02, 0);
        wr(ADDR_IRQ_CLEAR, 8'h03);
        rd(ADDR_IRQ_STATUS, 8'h00, 8'h02, 0);
        wr(ADDR_GATE_CONTROL, 8'h41);
        cyc(300);
        rd(ADDR_IRQ_STATUS, 8'h02, 8'h02, 0);
        wr(ADDR_TIMER_CONTROL, 8'h00);
        // rollover raises the level interrupt only while enabled
        wr(ADDR_IRQ_CLEAR, 8'h03);
        wr(ADDR_IRQ_ENABLE, 8'h01);
        `CHECK(irq, 1'b0)
        start(8'h41, 8'h00);
        wr(ADDR_COUNT_HIGH, 8'hff);
        wr(ADDR_COUNT_LOW, 8'hf0);
        for (i = 0; i < 100; i++)
        begin
            @(posedge clk);
            if (irq === 1'b1)
                break;
        end
        `CHECK(irq, 1'b1)
        wr(ADDR_TIMER_CONTROL, 8'h00);
        rd(ADDR_COUNT_HIGH, 8'h00, 8'hff, 0);
        rd(ADDR_IRQ_STATUS, 8'h01, 8'h01, 0);
        wr(ADDR_IRQ_ENABLE, 8'h00);
        cyc(2);
        `CHECK(irq, 1'b0)
        rd(ADDR_IRQ_STATUS, 8'h01, 8'h01, 0);
        wr(ADDR_IRQ_CLEAR, 8'h01);
        rd(ADDR_IRQ_STATUS, 8'h00, 8'h01, 0);
        cyc(4);
        finish_test();
    end
endmodule : tb_gated_16bit_counter
`default_nettype wire
